//--- dv/dacsl_host.sv
// Host serial master model driving the frame, clock and data pins.
// Assumes the bench calls xfer; clock idles high, frame high between words.
`timescale 1ns/1ps

module dacsl_host (
    // Serial link pins
    output logic frame_n,
    output logic sclk,
    output logic serial_in,
    input wire logic serial_out
);
    initial begin
        frame_n = 1'b1;
        sclk = 1'b1;
        serial_in = 1'b0;
    end

    // Period 800 ns, far below the top rate; short words abort
    task automatic xfer(input logic [15:0] word, input int nbits, output logic [15:0] got);
        got = '0;
        // Step off the bench clock edge the caller returned on
        #10;
        frame_n = 1'b0;
        #600;
        for (int i = 0; i < nbits; i++) begin
            serial_in = word[15-i];
            #100;
            got = {got[14:0], serial_out};
            sclk = 1'b0;
            #300;
            sclk = 1'b1;
            #400;
        end
        frame_n = 1'b1;
        serial_in = ~serial_in;
        #400;
    endtask : xfer
endmodule : dacsl_host

//--- dv/dacsl_top_tb.sv
// Self-checking bench of the DAC serial load and clear logic.
// Assumes the host model owns the serial pins; the bench owns the rest.
`timescale 1ns/1ps
`include "dacsl_params.svh"

module dacsl_top_tb;
    import dacsl_pkg::*;
    logic clk, rst, wr, rd, serial_out, frame_n, sclk, serial_in;
    logic async_zero_n, load_strobe_n, range_sel, over_temp;
    logic range_30v, analog_on, out_hiz, alarm_n, irq;
    logic [7:0] addr;
    logic [31:0] wdata, rdata;
    logic [15:0] rx;
    dacsl_code_t dac_code;
    int fail_count = 0;
    int checked = 0;

    dacsl_top u_dacsl_top (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .frame_n(frame_n), .sclk(sclk), .serial_in(serial_in),
        .serial_out(serial_out), .async_zero_n(async_zero_n),
        .load_strobe_n(load_strobe_n), .range_sel(range_sel), .over_temp(over_temp),
        .dac_code(dac_code), .range_30v(range_30v), .analog_on(analog_on),
        .out_hiz(out_hiz), .alarm_n(alarm_n), .irq(irq));

    dacsl_host u_dacsl_host (.frame_n(frame_n), .sclk(sclk), .serial_in(serial_in),
        .serial_out(serial_out));

    task automatic results;
        if (fail_count == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : results

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        chk(rdata, e);
    endtask : rd_chk

    // Pins pass a synchroniser and edge detector
    task automatic settle;
        repeat (8) @(posedge clk);
    endtask : settle

    task automatic frame(input logic [15:0] w, input int n);
        u_dacsl_host.xfer(w, n, rx);
        settle;
    endtask : frame

    task automatic irq_chk(input logic e);
        @(negedge clk);
        chk({31'h0, irq}, {31'h0, e});
    endtask : irq_chk

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    initial begin
        #2000000;
        fail_count++;
        results;
    end

    initial begin
        rst = 1'b1;
        addr = '0;
        wdata = '0;
        wr = 1'b0;
        rd = 1'b0;
        async_zero_n = 1'b1;
        load_strobe_n = 1'b1;
        range_sel = 1'b0;
        over_temp = 1'b0;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        settle;
        rd_chk(`DACSL_OFS_CTRL, 32'h40);
        rd_chk(`DACSL_OFS_DAC, 32'h0);
        rd_chk(8'h20, 32'h0);
        chk({29'h0, analog_on, out_hiz, alarm_n}, 32'h3);
        // Write without load, then an aborted word
        frame(16'h1abc, 16);
        rd_chk(`DACSL_OFS_INPUT, 32'habc);
        chk({20'h0, dac_code}, 32'h0);
        frame(16'h1555, 15);
        rd_chk(`DACSL_OFS_INPUT, 32'habc);
        rd_chk(`DACSL_OFS_STATUS, 32'h03);
        wr_reg(`DACSL_OFS_MASK, 32'h02);
        irq_chk(1'b1);
        wr_reg(`DACSL_OFS_STATUS, 32'h02);
        irq_chk(1'b0);
        rd_chk(`DACSL_OFS_STATUS, 32'h01);
        wr_reg(`DACSL_OFS_STATUS, 32'h1f);
        wr_reg(`DACSL_OFS_MASK, 32'h1f);
        // Load pulse
        @(posedge clk);
        load_strobe_n <= 1'b0;
        repeat (3) @(posedge clk);
        load_strobe_n <= 1'b1;
        settle;
        chk({20'h0, dac_code}, 32'habc);
        rd_chk(`DACSL_OFS_STATUS, 32'h10);
        irq_chk(1'b1);
        wr_reg(`DACSL_OFS_STATUS, 32'h1f);
        // Strobe held low: automatic update
        @(posedge clk);
        load_strobe_n <= 1'b0;
        frame(16'h1123, 16);
        chk({20'h0, dac_code}, 32'h123);
        // Readback one frame later
        frame(16'h9000, 16);
        frame(16'h0000, 16);
        chk({16'h0, rx}, 32'h0123);
        frame(16'ha000, 16);
        frame(16'h0000, 16);
        chk({16'h0, rx}, 32'h0040);
        // Clear, then writes and loads while held low
        @(posedge clk);
        async_zero_n <= 1'b0;
        settle;
        chk({20'h0, dac_code}, 32'h0);
        rd_chk(`DACSL_OFS_INPUT, 32'h0);
        frame(16'h1777, 16);
        chk({20'h0, dac_code}, 32'h0);
        load_strobe_n <= 1'b1;
        settle;
        load_strobe_n <= 1'b0;
        repeat (3) @(posedge clk);
        load_strobe_n <= 1'b1;
        settle;
        chk({20'h0, dac_code}, 32'h0);
        rd_chk(`DACSL_OFS_INPUT, 32'h777);
        async_zero_n <= 1'b1;
        settle;
        // Power-up, thermal shutdown and recovery
        frame(16'h2004, 16);
        chk({29'h0, alarm_n, analog_on, out_hiz}, 32'h6);
        over_temp <= 1'b1;
        settle;
        chk({29'h0, alarm_n, analog_on, out_hiz}, 32'h1);
        over_temp <= 1'b0;
        settle;
        chk({29'h0, alarm_n, analog_on, out_hiz}, 32'h5);
        frame(16'h2004, 16);
        chk({29'h0, alarm_n, analog_on, out_hiz}, 32'h6);
        range_sel <= 1'b1;
        settle;
        chk({31'h0, range_30v}, 32'h1);
        range_sel <= 1'b0;
        settle;
        chk({31'h0, range_30v}, 32'h0);
        // Reset in mid-run restores the power-on state
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        settle;
        rd_chk(`DACSL_OFS_CTRL, 32'h40);
        rd_chk(`DACSL_OFS_INPUT, 32'h0);
        chk({29'h0, alarm_n, analog_on, out_hiz}, 32'h5);
        results;
    end
endmodule : dacsl_top_tb

//--- rtl/dacsl_irq.sv
// Sticky event status, mask and level interrupt.
// Assumes events are one-cycle pulses on clk.
`timescale 1ns/1ps
`include "dacsl_params.svh"

module dacsl_irq
    import dacsl_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Events
    input wire dacsl_pkg::dacsl_ev_t ev,
    // Software access
    input wire logic clr_wr,
    input wire logic mask_wr,
    input wire dacsl_pkg::dacsl_ev_t wdata,
    // State
    output dacsl_pkg::dacsl_ev_t status,
    output dacsl_pkg::dacsl_ev_t mask,
    output logic irq
);
    import dacsl_pkg::*;

    genvar i;
    generate
        for (i = 0; i < `DACSL_EV_NUM; i++) begin : g_ev
            // Set beats a write-one clear in the same cycle
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    status[i] <= 1'b0;
                end else if (ev[i]) begin
                    status[i] <= 1'b1;
                end else if (clr_wr && wdata[i]) begin
                    status[i] <= 1'b0;
                end
            end
        end
    endgenerate

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mask <= '0;
        end else if (mask_wr) begin
            mask <= wdata;
        end
    end

    assign irq = |(status & mask);
endmodule : dacsl_irq

//--- rtl/dacsl_params.svh
// Constants of the serial DAC load and clear logic.
// Assumes inclusion by the package, design and bench files of this block only.
`ifndef DACSL_PARAMS_SVH
`define DACSL_PARAMS_SVH

// Register bus offsets
`define DACSL_OFS_STATUS 8'h00
`define DACSL_OFS_MASK 8'h04
`define DACSL_OFS_DAC 8'h08
`define DACSL_OFS_INPUT 8'h0c
`define DACSL_OFS_CTRL 8'h10
`define DACSL_OFS_PINS 8'h14

// Reset values
`define DACSL_CTRL_RST 8'h40
`define DACSL_CODE_RST 12'h000

// Control register fields
`define DACSL_CTRL_PWR 2
`define DACSL_CTRL_HIZ 6

// Serial word layout
`define DACSL_FRAME_BITS 5'h10
`define DACSL_CMD_RD 15
`define DACSL_CMD_SEL_HI 14
`define DACSL_CMD_SEL_LO 12

// Event bit positions
`define DACSL_EV_WRITE 0
`define DACSL_EV_ABORT 1
`define DACSL_EV_ZERO 2
`define DACSL_EV_HOT 3
`define DACSL_EV_LOAD 4
`define DACSL_EV_NUM 5

`endif

//--- rtl/dacsl_pkg.sv
// Types of the serial DAC load and clear logic.
// Assumes dacsl_params.svh sits beside it.
`include "dacsl_params.svh"

package dacsl_pkg;
    typedef logic [11:0] dacsl_code_t;
    typedef logic [15:0] dacsl_word_t;
    typedef logic [7:0] dacsl_ctrl_t;
    typedef logic [`DACSL_EV_NUM-1:0] dacsl_ev_t;
    typedef enum logic [2:0] {
        DACSL_SEL_NONE = 3'b000,
        DACSL_SEL_DAC = 3'b001,
        DACSL_SEL_CTRL = 3'b010
    } dacsl_sel_t;
endpackage : dacsl_pkg

//--- rtl/dacsl_sync.sv
// Two-flop synchroniser for a group of pins.
// Assumes pins are unrelated to clk; each bit is caught alone.
`timescale 1ns/1ps

module dacsl_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '0
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Pins in, synchronised levels out
    input wire logic [W-1:0] pin,
    output logic [W-1:0] lvl
);
    logic [W-1:0] meta_q;

    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    meta_q[i] <= INIT[i];
                    lvl[i] <= INIT[i];
                end else begin
                    meta_q[i] <= pin[i];
                    lvl[i] <= meta_q[i];
                end
            end
        end
    endgenerate
endmodule : dacsl_sync

//--- rtl/dacsl_top.sv
// Serial load, clear, readback and alarm logic of a 12-bit DAC.
// Assumes all pins are asynchronous to clk and the serial clock is well below clk/4.
`timescale 1ns/1ps
`include "dacsl_params.svh"

module dacsl_top
    import dacsl_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Register port
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    // Serial link pins
    input wire logic frame_n,
    input wire logic sclk,
    input wire logic serial_in,
    output logic serial_out,
    // Control pins
    input wire logic async_zero_n,
    input wire logic load_strobe_n,
    input wire logic range_sel,
    input wire logic over_temp,
    // Analog side and alarm
    output dacsl_pkg::dacsl_code_t dac_code,
    output logic range_30v,
    output logic analog_on,
    output logic out_hiz,
    output logic alarm_n,
    output logic irq
);
    import dacsl_pkg::*;

    // Synchronised pins
    logic zero_s, frm_s, sck_s, sin_s, load_s, hot_s, rng_s;
    logic zero_p_q, frm_p_q, sck_p_q, load_p_q, hot_p_q;
    logic frm_n_w;
    assign frm_n_w = frame_n;

    // Idle levels: clear, frame, clock and load high; data, hot and range low
    dacsl_sync #(
        .W(7),
        .INIT(7'h74)
    ) u_sync (
        .clk(clk),
        .rst(rst),
        .pin({async_zero_n, frm_n_w, sclk, serial_in, load_strobe_n, over_temp, range_sel}),
        .lvl({zero_s, frm_s, sck_s, sin_s, load_s, hot_s, rng_s})
    );

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            zero_p_q <= 1'b1;
            frm_p_q <= 1'b1;
            sck_p_q <= 1'b1;
            load_p_q <= 1'b1;
            hot_p_q <= 1'b0;
        end else begin
            zero_p_q <= zero_s;
            frm_p_q <= frm_s;
            sck_p_q <= sck_s;
            load_p_q <= load_s;
            hot_p_q <= hot_s;
        end
    end

    // Edge strobes
    wire zero_fall = zero_p_q && !zero_s;
    wire frm_fall = frm_p_q && !frm_s;
    wire frm_rise = !frm_p_q && frm_s;
    wire sck_fall = sck_p_q && !sck_s;
    wire sck_rise = !sck_p_q && sck_s;
    wire load_fall = load_p_q && !load_s;
    wire hot_rise = !hot_p_q && hot_s;

    // Frame state
    logic act_q, act_d;
    logic [4:0] cnt_q, cnt_d;
    dacsl_word_t sh_q, sh_d;
    dacsl_word_t ro_q, ro_d;
    logic so_q, so_d;
    dacsl_sel_t rb_q, rb_d;

    wire taking = act_q && sck_fall && (cnt_q < `DACSL_FRAME_BITS);
    wire frame_done = taking && (cnt_q == `DACSL_FRAME_BITS - 5'h01);
    wire frame_abort = act_q && frm_rise && (cnt_q < `DACSL_FRAME_BITS) && !frame_done;
    wire [15:0] word_w = {sh_q[14:0], sin_s};
    wire [2:0] sel_bits = word_w[`DACSL_CMD_SEL_HI:`DACSL_CMD_SEL_LO];
    wire is_read = word_w[`DACSL_CMD_RD];
    wire wr_dac = frame_done && !is_read && (sel_bits == DACSL_SEL_DAC);
    wire wr_ctrl = frame_done && !is_read && (sel_bits == DACSL_SEL_CTRL);
    wire rd_cmd = frame_done && is_read;

    // Registers seen by the DAC
    dacsl_code_t in_q, in_d;
    dacsl_code_t dac_q, dac_d;
    dacsl_ctrl_t ctrl_q, ctrl_d;
    logic therm_q, therm_d;

    wire load_ok = zero_s && load_fall;
    wire auto_ok = wr_dac && zero_s && !load_s;
    wire pwr_cmd = wr_ctrl && word_w[`DACSL_CTRL_PWR];

    // Readback word of the register picked by the last read command
    wire [15:0] rb_word = (rb_q == DACSL_SEL_CTRL) ? {8'h00, ctrl_q} :
                          (rb_q == DACSL_SEL_DAC) ? {4'h0, dac_q} : 16'h0000;

    always_comb begin
        act_d = act_q;
        cnt_d = cnt_q;
        sh_d = sh_q;
        ro_d = ro_q;
        so_d = so_q;
        rb_d = rb_q;
        if (frm_fall) begin
            act_d = 1'b1;
            cnt_d = 5'h00;
            ro_d = {rb_word[14:0], 1'b0};
            so_d = rb_word[15];
        end else if (frm_rise) begin
            act_d = 1'b0;
        end else begin
            if (taking) begin
                sh_d = word_w;
                cnt_d = cnt_q + 5'h01;
            end
            if (act_q && sck_rise) begin
                so_d = ro_q[15];
                ro_d = {ro_q[14:0], 1'b0};
            end
        end
        if (rd_cmd) begin
            rb_d = dacsl_sel_t'(sel_bits);
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            act_q <= 1'b0;
            cnt_q <= 5'h00;
            sh_q <= 16'h0000;
            ro_q <= 16'h0000;
            so_q <= 1'b0;
            rb_q <= DACSL_SEL_NONE;
        end else begin
            act_q <= act_d;
            cnt_q <= cnt_d;
            sh_q <= sh_d;
            ro_q <= ro_d;
            so_q <= so_d;
            rb_q <= rb_d;
        end
    end

    // Input and DAC registers; clear has priority
    always_comb begin
        in_d = in_q;
        dac_d = dac_q;
        if (zero_fall) begin
            in_d = `DACSL_CODE_RST;
            dac_d = `DACSL_CODE_RST;
        end else begin
            if (wr_dac) begin
                in_d = word_w[11:0];
            end
            if (auto_ok) begin
                dac_d = word_w[11:0];
            end else if (load_ok) begin
                dac_d = in_q;
            end
        end
    end

    // Control register and thermal shutdown
    always_comb begin
        ctrl_d = ctrl_q;
        therm_d = therm_q;
        if (wr_ctrl) begin
            ctrl_d = word_w[7:0];
            if (pwr_cmd) begin
                therm_d = 1'b0;
            end
        end
        if (hot_rise) begin
            ctrl_d[`DACSL_CTRL_PWR] = 1'b0;
            therm_d = 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            in_q <= `DACSL_CODE_RST;
            dac_q <= `DACSL_CODE_RST;
            ctrl_q <= `DACSL_CTRL_RST;
            therm_q <= 1'b0;
        end else begin
            in_q <= in_d;
            dac_q <= dac_d;
            ctrl_q <= ctrl_d;
            therm_q <= therm_d;
        end
    end

    // Analog-side outputs
    logic rng_q, on_q, hiz_q, alarm_q;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rng_q <= 1'b0;
            on_q <= 1'b0;
            hiz_q <= 1'b1;
            alarm_q <= 1'b1;
        end else begin
            rng_q <= rng_s;
            on_q <= ctrl_q[`DACSL_CTRL_PWR] && !therm_q;
            hiz_q <= therm_q || (!ctrl_q[`DACSL_CTRL_PWR] && ctrl_q[`DACSL_CTRL_HIZ]);
            alarm_q <= !hot_s;
        end
    end

    assign dac_code = dac_q;
    assign range_30v = rng_q;
    assign analog_on = on_q;
    assign out_hiz = hiz_q;
    assign alarm_n = alarm_q;
    assign serial_out = so_q;

    // Events and interrupt
    dacsl_ev_t ev, st, msk;
    assign ev[`DACSL_EV_WRITE] = frame_done;
    assign ev[`DACSL_EV_ABORT] = frame_abort;
    assign ev[`DACSL_EV_ZERO] = zero_fall;
    assign ev[`DACSL_EV_HOT] = hot_rise;
    assign ev[`DACSL_EV_LOAD] = load_ok || auto_ok;

    wire st_wr = wr && (addr == `DACSL_OFS_STATUS);
    wire mask_wr = wr && (addr == `DACSL_OFS_MASK);

    dacsl_irq u_irq (
        .clk(clk),
        .rst(rst),
        .ev(ev),
        .clr_wr(st_wr),
        .mask_wr(mask_wr),
        .wdata(wdata[`DACSL_EV_NUM-1:0]),
        .status(st),
        .mask(msk),
        .irq(irq)
    );

    // Register read port
    wire [31:0] rd_mux =
        (addr == `DACSL_OFS_STATUS) ? {27'h0, st} :
        (addr == `DACSL_OFS_MASK) ? {27'h0, msk} :
        (addr == `DACSL_OFS_DAC) ? {20'h0, dac_q} :
        (addr == `DACSL_OFS_INPUT) ? {20'h0, in_q} :
        (addr == `DACSL_OFS_CTRL) ? {24'h0, ctrl_q} :
        (addr == `DACSL_OFS_PINS) ? {29'h0, therm_q, rng_q, alarm_q} : 32'h0;

    logic [31:0] rdata_q;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata_q <= 32'h0;
        end else begin
            rdata_q <= rd ? rd_mux : 32'h0;
        end
    end
    assign rdata = rdata_q;

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_frame_open;
        frm_fall ##1 (act_q && cnt_q == 5'h00);
    endsequence

    sequence s_last_bit;
        act_q && cnt_q == 5'h0f && sck_fall;
    endsequence

    AST_CLEAR_EDGE: assert property (zero_fall |=> (dac_q == 12'h000))
        else $error("clear edge did not zero the DAC register");
    AST_CLEAR_BOTH: assert property (zero_fall |=> (in_q == 12'h000 && dac_q == 12'h000))
        else $error("clear left a register non-zero");
    AST_LOAD_BLOCKED: assert property ((!zero_s && !zero_fall) |=> $stable(dac_q))
        else $error("DAC register moved while clear was low");
    AST_FRAME_OPEN: assert property (frm_fall |-> s_frame_open)
        else $error("frame did not open on sync fall");
    AST_UPDATE_16: assert property (wr_dac && !zero_fall |-> s_last_bit ##1 (in_q == $past(word_w[11:0])))
        else $error("input register not written on the sixteenth edge");
    AST_ABORT: assert property (frame_abort && !hot_rise && !zero_fall |=>
        $stable(in_q) && $stable(ctrl_q))
        else $error("aborted frame changed a register");
    AST_SHIFT: assert property (taking |=> sh_q[0] == $past(sin_s) && cnt_q == $past(cnt_q) + 5'h01)
        else $error("shift register missed a bit");
    AST_LAUNCH: assert property (act_q && sck_rise && !frm_fall && !frm_rise |=>
        serial_out == $past(ro_q[15]))
        else $error("readback bit not launched on rising clock");
    AST_LOAD_COPY: assert property (load_ok && !zero_fall && !wr_dac |=> dac_q == $past(in_q))
        else $error("load pulse did not copy input register");
    AST_AUTO: assert property (auto_ok && !zero_fall |=> dac_q == in_q)
        else $error("held load did not auto update");
    AST_RANGE: assert property ($changed(rng_s) |=> range_30v == $past(rng_s))
        else $error("range output does not follow pin");
    AST_ALARM: assert property (hot_s |=> !alarm_n)
        else $error("alarm not raised while hot");
    AST_THERM_HOLD: assert property (therm_q && !pwr_cmd |=> therm_q ##1 !analog_on)
        else $error("left thermal shutdown without power-up command");

    // Abort, power, pin and DAC hold checks
    AST_ABORT_IDLE: assert property (frame_abort |=> !act_q)
        else $error("aborted frame left the shifter open");
    AST_POWER_UP: assert property (pwr_cmd && !hot_rise |=> ctrl_q[`DACSL_CTRL_PWR] && !therm_q)
        else $error("power-up command did not power the analog section");
    AST_HOT_OFF: assert property (hot_rise |=> therm_q && !ctrl_q[`DACSL_CTRL_PWR])
        else $error("over-temperature did not power down");
    AST_ALARM_IDLE: assert property (!hot_s |=> alarm_n)
        else $error("alarm raised while not hot");
    AST_RANGE_LOW: assert property (!rng_s |=> !range_30v)
        else $error("range output high while pin low");
    AST_DAC_HOLD: assert property (!zero_fall && !load_ok && !auto_ok |=> $stable(dac_q))
        else $error("DAC register changed without load, update or clear");
endmodule : dacsl_top
